// *** inc/rtcc_pkg.sv ***
// shared constants, register map and state types of the time counter block
package rtcc_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address on the bus is four times the index
    // ------------------------------------------------------------------
    localparam logic [15:0] CTL_IDX  = 16'h56C0;
    localparam logic [15:0] IEN_IDX  = 16'h56C2;
    localparam logic [15:0] IFLG_IDX = 16'h56C4;
    localparam logic [15:0] MS_IDX   = 16'h56C6;
    localparam logic [15:0] HR_IDX   = 16'h56C8;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTL_RUN_BIT    = 0;
    localparam int CTL_FMT12_BIT  = 4;
    localparam int CTL_BCD_BIT    = 5;
    localparam int CTL_STATUS_BIT = 8;
    localparam int MS_SEC_LSB     = 0;
    localparam int MS_MIN_LSB     = 8;
    localparam int HR_HOUR_LSB    = 0;
    localparam int HR_PM_BIT      = 8;
    localparam int FLAG_W         = 10;

    // periodic flag positions in the enable and flag registers
    localparam int F_32HZ   = 0;
    localparam int F_8HZ    = 1;
    localparam int F_4HZ    = 2;
    localparam int F_1HZ    = 3;
    localparam int F_10SEC  = 4;
    localparam int F_1MIN   = 5;
    localparam int F_10MIN  = 6;
    localparam int F_1HOUR  = 7;
    localparam int F_HALFD  = 8;
    localparam int F_1DAY   = 9;

    // ------------------------------------------------------------------
    // values after reset and counts
    // ------------------------------------------------------------------
    localparam logic              RUN_RST    = 1'b0;
    localparam logic              FMT12_RST  = 1'b0;
    localparam logic              BCD_RST    = 1'b0;
    localparam logic [FLAG_W-1:0] FLAG_RST   = 10'h000;
    localparam logic [7:0]        PRESC_RST  = 8'h00;
    localparam int                TICK_HZ    = 256;
    localparam logic [7:0]        PRESC_LAST = 8'(TICK_HZ - 1);
    localparam logic [6:0]        LAST_SECMIN = 7'h3B;
    localparam logic [6:0]        LAST_HOUR24 = 7'h17;
    localparam logic [6:0]        HOUR_11     = 7'h0B;
    localparam logic [6:0]        HOUR_12     = 7'h0C;
    localparam logic [6:0]        DECADE      = 7'h0A;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CTL  = 3'b001,
        SEL_IEN  = 3'b010,
        SEL_IFLG = 3'b011,
        SEL_MS   = 3'b100,
        SEL_HR   = 3'b101
    } rtcc_sel_type;

    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic       pm;
    } rtcc_time_type;

    typedef struct packed {
        logic              run;
        logic              fmt12;
        logic              bcd;
        logic              status;
        logic              div_rst;
        logic [7:0]        presc;
        logic [FLAG_W-1:0] ien;
        logic [FLAG_W-1:0] iflg;
        rtcc_time_type     tm;
        logic              ap_valid;
        logic              ap_write;
        rtcc_sel_type      ap_sel;
        logic [31:0]       hrdata;
        logic              hready;
    } rtcc_state_type;

endpackage

// *** logic/rtcc_top.sv ***
// time counter block: seconds, minutes, hours behind an ahb-lite slave
//
// Notes on behaviour
// [RL1] seconds count 0 to 59 on 1 Hz
// [RL2] seconds 59 wrap to 0, carry minutes
// [RL3] minutes count 0 to 59 on carry
// [RL4] minutes 59 wrap to 0, carry hours
// [RL5] hours 0-23 or 1-12 by format
// [RL6] bcd seconds/minutes: 3-bit tens, 4-bit units
// [RL7] bcd hours: 2-bit tens, 4-bit units
// [RL8] 12-hour twelve reads 0xC or 0x12
// [RL9] pm bit only in 12-hour, else 0
// [RL10] format bit 1 selects 12-hour, control register
// [RL11] software changes format only while idle
// [RL12] counters keep contents through reset
// [RL13] counting runs from 256 Hz tick
// [RL14] tick gated off while run is 0
// [RL15] writing run 1 resets the divider
// [RL16] run is 0 after reset
// [RL17] count while run 1, halt at 0
// [RL18] status follows actual running state
// [RL19] software stops, polls status, loads, restarts
// [RL20] software writes only stopped, in range
// [RL21] software reads twice or after 1 Hz
// [RL22] boundary flag may follow start at once
// [RL23] 12-hour: 11 to 12 flips pm
// [RL24] flags set when enabled, write-one clears
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps

module rtcc_top
    import rtcc_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    input  wire logic        TICK_256HZ,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             DIV_RST,
    output logic             RUN_STATUS
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // counter value as plain binary, whatever the current mode
    function automatic logic [6:0] to_bin(input logic [6:0] v, input logic bcd);
        to_bin = bcd ? 7'({4'h0, v[6:4]} * DECADE) + {3'h0, v[3:0]} : v;
    endfunction

    // binary value back into the current counter format
    function automatic logic [6:0] from_bin(input logic [6:0] b, input logic bcd);
        from_bin = bcd ? {3'(b / DECADE), 4'(b % DECADE)} : b;
    endfunction

    // byte address to register select; anything else is unmapped
    function automatic rtcc_sel_type decode(input logic [31:0] a);
        if (a == 32'({CTL_IDX, 2'b00})) begin
            decode = SEL_CTL;
        end else if (a == 32'({IEN_IDX, 2'b00})) begin
            decode = SEL_IEN;
        end else if (a == 32'({IFLG_IDX, 2'b00})) begin
            decode = SEL_IFLG;
        end else if (a == 32'({MS_IDX, 2'b00})) begin
            decode = SEL_MS;
        end else if (a == 32'({HR_IDX, 2'b00})) begin
            decode = SEL_HR;
        end else begin
            decode = SEL_NONE;
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    rtcc_state_type st_r;
    rtcc_state_type st_nxt;

    // step strobes, visible for the checks below
    logic       tick_g;
    logic       sec_step;
    logic       min_step;
    logic       hour_step;
    logic       ap_take;
    logic [6:0] sec_b;
    logic [6:0] min_b;
    logic [6:0] hour_b;
    logic [6:0] sec_nb;
    logic [6:0] min_nb;
    logic [6:0] hour_nb;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clr;
    logic [7:0] presc_inc;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt  = st_r;
        flag_set = '0;
        flag_clr = '0;
        st_nxt.div_rst = 1'b0;
        st_nxt.hready  = 1'b1;

        // the tick only reaches the counters while run is set
        tick_g    = TICK_256HZ & st_r.run;                        // [RL13] [RL14] [RL17]
        presc_inc = st_r.presc + 8'h01;
        sec_step  = tick_g && (st_r.presc == PRESC_LAST);         // [RL1]

        // work in binary, convert back to the held format
        sec_b   = to_bin(st_r.tm.sec, st_r.bcd);                  // [RL6]
        min_b   = to_bin(st_r.tm.min, st_r.bcd);
        hour_b  = to_bin({1'b0, st_r.tm.hour}, st_r.bcd);         // [RL7]
        sec_nb  = (sec_b == LAST_SECMIN) ? 7'h00 : sec_b + 7'h01; // [RL2]
        min_nb  = (min_b == LAST_SECMIN) ? 7'h00 : min_b + 7'h01; // [RL4]
        min_step  = sec_step && (sec_b == LAST_SECMIN);           // [RL2]
        hour_step = min_step && (min_b == LAST_SECMIN);           // [RL4]

        // hour wrap depends on format; twelve follows eleven in 12-hour
        if (st_r.fmt12) begin
            hour_nb = (hour_b == HOUR_12) ? 7'h01 : hour_b + 7'h01; // [RL5] [RL8] [RL23]
        end else begin
            hour_nb = (hour_b == LAST_HOUR24) ? 7'h00 : hour_b + 7'h01; // [RL5]
        end

        // divider and counter cascade
        if (tick_g) begin
            st_nxt.presc = presc_inc;
            if (presc_inc[2:0] == 3'h0) begin
                flag_set[F_32HZ] = 1'b1;
            end
            if (presc_inc[4:0] == 5'h00) begin
                flag_set[F_8HZ] = 1'b1;
            end
            if (presc_inc[5:0] == 6'h00) begin
                flag_set[F_4HZ] = 1'b1;
            end
        end
        if (sec_step) begin
            st_nxt.tm.sec = from_bin(sec_nb, st_r.bcd);           // [RL1]
            flag_set[F_1HZ] = 1'b1;
            flag_set[F_10SEC] = ((sec_nb % DECADE) == 7'h00);
            flag_set[F_1MIN]  = min_step;
        end
        if (min_step) begin
            st_nxt.tm.min = from_bin(min_nb, st_r.bcd);           // [RL3]
            flag_set[F_10MIN] = ((min_nb % DECADE) == 7'h00);
            flag_set[F_1HOUR] = hour_step;
        end
        if (hour_step) begin
            st_nxt.tm.hour = 6'(from_bin(hour_nb, st_r.bcd));     // [RL5]
            if (st_r.fmt12) begin
                // pm flips only on the eleven to twelve step
                if (hour_b == HOUR_11) begin
                    st_nxt.tm.pm = ~st_r.tm.pm;                   // [RL23]
                    flag_set[F_HALFD] = 1'b1;
                    flag_set[F_1DAY]  = st_r.tm.pm;
                end
            end else begin
                st_nxt.tm.pm = 1'b0;                              // [RL9]
                if (hour_b == HOUR_11 || hour_b == LAST_HOUR24) begin
                    flag_set[F_HALFD] = 1'b1;
                end
                flag_set[F_1DAY] = (hour_b == LAST_HOUR24);
            end
        end

        // status trails run by one cycle: it drops once the gate is shut
        st_nxt.status = st_r.run;                                 // [RL18]

        // ahb address phase: only whole-word transfers are taken
        ap_take = HSEL && HREADY && HTRANS[1] && (HSIZE == 3'h2);
        st_nxt.ap_valid = ap_take;
        st_nxt.ap_write = HWRITE;
        st_nxt.ap_sel   = ap_take ? decode(HADDR) : SEL_NONE;

        // data-phase write; unmapped writes are dropped with OKAY
        if (st_r.ap_valid && st_r.ap_write) begin
            case (st_r.ap_sel)
                SEL_CTL: begin
                    st_nxt.run   = HWDATA[CTL_RUN_BIT];           // [RL17]
                    st_nxt.fmt12 = HWDATA[CTL_FMT12_BIT];         // [RL10]
                    st_nxt.bcd   = HWDATA[CTL_BCD_BIT];           // [RL6]
                    if (HWDATA[CTL_RUN_BIT]) begin
                        // a fresh divider period starts with every start
                        st_nxt.presc   = PRESC_RST;               // [RL15]
                        st_nxt.div_rst = 1'b1;                    // [RL15]
                    end
                end
                SEL_IEN: begin
                    st_nxt.ien = HWDATA[FLAG_W-1:0];
                end
                SEL_IFLG: begin
                    flag_clr = HWDATA[FLAG_W-1:0];                // [RL24]
                end
                SEL_MS: begin
                    // loaded value is the base of the next step, so a
                    // boundary flag can come on the first second
                    st_nxt.tm.sec = HWDATA[MS_SEC_LSB +: 7];      // [RL22]
                    st_nxt.tm.min = HWDATA[MS_MIN_LSB +: 7];
                end
                SEL_HR: begin
                    st_nxt.tm.hour = HWDATA[HR_HOUR_LSB +: 6];
                    st_nxt.tm.pm   = HWDATA[HR_PM_BIT];           // [RL9]
                end
                default: begin
                end
            endcase
        end

        // set wins over a clear in the same cycle; disabled causes never set
        st_nxt.iflg = (st_r.iflg & ~flag_clr) | (flag_set & st_r.ien); // [RL24]

        // read data is sampled in the address phase
        if (ap_take && !HWRITE) begin
            case (decode(HADDR))
                SEL_CTL: begin
                    st_nxt.hrdata = '0;
                    st_nxt.hrdata[CTL_RUN_BIT]    = st_r.run;
                    st_nxt.hrdata[CTL_FMT12_BIT]  = st_r.fmt12;
                    st_nxt.hrdata[CTL_BCD_BIT]    = st_r.bcd;
                    st_nxt.hrdata[CTL_STATUS_BIT] = st_r.status;  // [RL18]
                end
                SEL_IEN: begin
                    st_nxt.hrdata = 32'(st_r.ien);
                end
                SEL_IFLG: begin
                    st_nxt.hrdata = 32'(st_r.iflg);
                end
                SEL_MS: begin
                    st_nxt.hrdata = '0;
                    st_nxt.hrdata[MS_SEC_LSB +: 7] = st_r.tm.sec;
                    st_nxt.hrdata[MS_MIN_LSB +: 7] = st_r.tm.min;
                end
                SEL_HR: begin
                    st_nxt.hrdata = '0;
                    st_nxt.hrdata[HR_HOUR_LSB +: 6] = st_r.tm.hour;
                    // pm reads as zero in 24-hour format
                    st_nxt.hrdata[HR_PM_BIT] = st_r.tm.pm & st_r.fmt12; // [RL9]
                end
                default: begin
                    st_nxt.hrdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register; time fields are left alone by reset
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_r.run      <= RUN_RST;                             // [RL16]
            st_r.fmt12    <= FMT12_RST;
            st_r.bcd      <= BCD_RST;
            st_r.status   <= 1'b0;
            st_r.div_rst  <= 1'b0;
            st_r.presc    <= PRESC_RST;
            st_r.ien      <= FLAG_RST;
            st_r.iflg     <= FLAG_RST;
            st_r.ap_valid <= 1'b0;
            st_r.ap_write <= 1'b0;
            st_r.ap_sel   <= SEL_NONE;
            st_r.hrdata   <= 32'h0000_0000;
            st_r.hready   <= 1'b1;
            st_r.tm       <= st_nxt.tm;                           // [RL12]
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign HRDATA     = st_r.hrdata;
    assign HREADYOUT  = st_r.hready;
    assign HRESP      = 1'b0 & st_r.hready;
    assign DIV_RST    = st_r.div_rst;
    assign RUN_STATUS = st_r.status;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_sec_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL2]
        (sec_step && !st_r.bcd && st_r.tm.sec == 7'h3B && !st_nxt.ap_valid
            && !(st_r.ap_valid && st_r.ap_write))
        |=> (st_r.tm.sec == 7'h00))
        else $error("seconds did not wrap to zero");

    a_min_carry: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL4]
        (sec_step && !st_r.bcd && st_r.tm.sec == 7'h3B && st_r.tm.min == 7'h3B
            && !(st_r.ap_valid && st_r.ap_write))
        |=> (st_r.tm.min == 7'h00))
        else $error("minutes did not wrap on carry");

    a_hour_24wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL5]
        (hour_step && !st_r.fmt12 && !st_r.bcd && st_r.tm.hour == 6'h17
            && !(st_r.ap_valid && st_r.ap_write))
        |=> (st_r.tm.hour == 6'h00))
        else $error("24-hour counter did not wrap");

    a_hour_12wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL23]
        (hour_step && st_r.fmt12 && !st_r.bcd && st_r.tm.hour == 6'h0C
            && !(st_r.ap_valid && st_r.ap_write))
        |=> (st_r.tm.hour == 6'h01) && $stable(st_r.tm.pm))
        else $error("12-hour twelve did not step to one");

    a_halt_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL17]
        (!st_r.run && !(st_r.ap_valid && st_r.ap_write)) [*2]
        |-> $stable(st_r.tm.sec) && $stable(st_r.presc))
        else $error("counters moved while stopped");

    a_status_drop: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL18]
        $fell(st_r.run) |=> !RUN_STATUS ##1 !RUN_STATUS || st_r.run)
        else $error("status did not fall after stop");

    a_div_restart: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL15]
        (st_r.ap_valid && st_r.ap_write && st_r.ap_sel == SEL_CTL && HWDATA[0])
        |=> DIV_RST && st_r.presc == 8'h00 ##1 !DIV_RST)
        else $error("start did not restart the divider");

    a_pm_read24: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL9]
        (ap_take && !HWRITE && decode(HADDR) == SEL_HR && !st_r.fmt12)
        |=> HRDATA[8] == 1'b0)
        else $error("pm bit read as one in 24-hour format");

    a_flag_enable: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL24]
        (sec_step && st_r.ien[3]) |=> st_r.iflg[3])
        else $error("enabled 1 Hz flag not set");

    a_flag_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL24]
        (!st_r.ien[3] && !st_r.iflg[3]) |=> !st_r.iflg[3])
        else $error("disabled 1 Hz flag was set");

    a_tick_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL14]
        (!st_r.run && TICK_256HZ) |-> !sec_step && !tick_g)
        else $error("tick reached counters while stopped");

    a_pm_flip: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL23]
        (hour_step && st_r.fmt12 && !st_r.bcd && st_r.tm.hour == 6'h0B
            && !(st_r.ap_valid && st_r.ap_write))
        |=> (st_r.tm.hour == 6'h0C) && (st_r.tm.pm != $past(st_r.tm.pm)))
        else $error("eleven to twelve did not flip pm");

    a_pm_clear24: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL9]
        (hour_step && !st_r.fmt12 && !(st_r.ap_valid && st_r.ap_write))
        |=> !st_r.tm.pm)
        else $error("pm stayed set in 24-hour counting");

    a_status_rise: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL18]
        $rose(st_r.run) |=> RUN_STATUS)
        else $error("status did not rise after start");

    a_fmt_write: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL10]
        (st_r.ap_valid && st_r.ap_write && st_r.ap_sel == SEL_CTL && HWDATA[CTL_FMT12_BIT])
        |=> st_r.fmt12)
        else $error("format bit not taken from control write");

    a_flag_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL24]
        (st_r.ap_valid && st_r.ap_write && st_r.ap_sel == SEL_IFLG && flag_set == '0)
        |=> (({22'h0, st_r.iflg} & $past(HWDATA)) == 32'h0000_0000))
        else $error("written flag was not cleared");

    a_div_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RL15]
        !(st_r.ap_valid && st_r.ap_write && st_r.ap_sel == SEL_CTL && HWDATA[CTL_RUN_BIT])
        |=> !DIV_RST)
        else $error("divider restart without a start write");

endmodule

// *** testbench/tb_rtc_time_counters.sv ***
// self-checking testbench of the time counter block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, (a), (b)); end end

module tb_rtc_time_counters import rtcc_pkg::*;;

    // ----------------------------------------
    // bench signals, all inputs set at time zero
    // ----------------------------------------
    logic        ref_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0000_0000;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [2:0]  hsize     = 3'h2;
    logic [31:0] hwdata    = 32'h0000_0000;
    logic        tick      = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        div_rst;
    logic        run_status;
    int          failures  = 0;
    int          check_count = 0;
    int          div_cnt   = 0;
    logic [31:0] ien_v     = 32'h0000_03F0;
    logic [31:0] r;
    int          corner [4] = '{86398, 3598, 43198, 46798};

    // 10 MHz reference clock
    always #50 ref_clk = ~ref_clk;

    // count divider restart pulses so a double pulse shows up
    always @(posedge ref_clk) begin
        if (div_rst === 1'b1) begin
            div_cnt <= div_cnt + 1;
        end
    end

    rtcc_top dut_u (
        .REF_CLK    (ref_clk),
        .RST_N      (rst_n),
        .HSEL       (hsel),
        .HADDR      (haddr),
        .HTRANS     (htrans),
        .HWRITE     (hwrite),
        .HSIZE      (hsize),
        .HWDATA     (hwdata),
        .HREADY     (hreadyout),
        .TICK_256HZ (tick),
        .HRDATA     (hrdata),
        .HREADYOUT  (hreadyout),
        .HRESP      (hresp),
        .DIV_RST    (div_rst),
        .RUN_STATUS (run_status)
    );

    // ----------------------------------------
    // expectation functions, time held as seconds of day
    // ----------------------------------------
    function automatic logic [7:0] enc(input int v, input logic b);
        return b ? 8'((v / 10) * 16 + v % 10) : 8'(v);
    endfunction

    function automatic logic [31:0] exp_ms(input int t, input logic b);
        return {16'h0000, enc((t / 60) % 60, b), enc(t % 60, b)};
    endfunction

    // twelve-hour view: hours 0 and 12 both read as twelve
    function automatic logic [31:0] exp_hr(input int t, input logic f12, input logic b);
        int h;
        h = t / 3600;
        if (f12) begin
            return {23'h000000, (h >= 12), enc((h % 12 == 0) ? 12 : h % 12, b)};
        end
        return {24'h000000, enc(h, b)};
    endfunction

    // rate flags all come within a case's 768 ticks; m is the enable mask
    function automatic logic [31:0] exp_flags(input int t, input int n, input logic [31:0] m);
        logic [31:0] f;
        int          u;
        f = 32'h0000_0000;
        if (n > 0) f[F_1HZ:F_32HZ] = 4'hF;
        for (int i = 1; i <= n; i++) begin
            u = (t + i) % 86400;
            if (u % 10 == 0) f[F_10SEC] = 1'b1;
            if (u % 60 == 0) f[F_1MIN] = 1'b1;
            if (u % 600 == 0) f[F_10MIN] = 1'b1;
            if (u % 3600 == 0) f[F_1HOUR] = 1'b1;
            if (u % 43200 == 0) f[F_HALFD] = 1'b1;
            if (u == 0) f[F_1DAY] = 1'b1;
        end
        return f & m;
    endfunction

    // ----------------------------------------
    // bus and tick drivers
    // ----------------------------------------
    // one single word transfer; address held until hready seen at an edge
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd_data);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd_data = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] d);
        bus(1'b0, idx, 32'h0000_0000, d);
    endtask

    // one-cycle tick pulses with a gap, as the clock generator gives them
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            tick <= 1'b1;
            @(posedge ref_clk);
            tick <= 1'b0;
        end
    endtask

    // stop and poll status, as software must before loading counters
    task automatic halt(input logic [31:0] ctl);
        logic [31:0] q;
        int          n;
        wr(CTL_IDX, ctl);
        n = 0;
        do begin
            rd(CTL_IDX, q);
            n++;
        end while (q[CTL_STATUS_BIT] !== 1'b0 && n < 20);
        `CHK(q, ctl)
    endtask

    // ----------------------------------------
    // one load, start, count, stop sequence
    // ----------------------------------------
    task automatic run_case(input int t, input logic f12, input logic b);
        logic [31:0] c;
        logic [31:0] q;
        int          d;
        c = (32'(b) << CTL_BCD_BIT) | (32'(f12) << CTL_FMT12_BIT);
        halt(c);
        wr(IFLG_IDX, 32'h0000_03FF);
        wr(MS_IDX, exp_ms(t, b));
        // pm written as 1 in 24-hour mode must still read back 0
        wr(HR_IDX, exp_hr(t, f12, b) | (f12 ? 32'h0000_0000 : 32'h0000_0100));
        d = div_cnt;
        wr(CTL_IDX, c | 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        `CHK(div_cnt, d + 1)
        `CHK(run_status, 1'b1)
        ticks(255);
        // no tick during reads, so one read is exact
        rd(MS_IDX, q);
        `CHK(q, exp_ms(t, b))
        ticks(513);
        rd(MS_IDX, q);
        `CHK(q, exp_ms((t + 3) % 86400, b))
        rd(HR_IDX, q);
        `CHK(q, exp_hr((t + 3) % 86400, f12, b))
        rd(IFLG_IDX, q);
        `CHK(q, exp_flags(t, 3, ien_v))
        wr(IFLG_IDX, q);
        rd(IFLG_IDX, q);
        `CHK(q, 32'h0000_0000)
        halt(c);
        ticks(300);
        rd(MS_IDX, q);
        `CHK(q, exp_ms((t + 3) % 86400, b))
        $display("case t=%0d f12=%0d bcd=%0d done", t, f12, b);
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        r = $urandom(32'h7594);
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(CTL_IDX, r);
        `CHK(r, 32'h0000_0000)
        ien_v = 32'h0000_03FF;
        wr(IEN_IDX, ien_v);
        repeat (3) begin
            run_case($urandom % 86400, 1'($urandom), 1'($urandom));
        end
        ien_v = 32'h0000_03F0;
        wr(IEN_IDX, ien_v);
        // binary 24-hour runs last so the retention check reads it directly
        for (int f = 1; f >= 0; f--) begin
            for (int b = 1; b >= 0; b--) begin
                foreach (corner[i]) begin
                    run_case(corner[i], f[0], b[0]);
                end
            end
        end
        // format and bcd set so that reset has something to clear
        wr(CTL_IDX, 32'h0000_0030);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(CTL_IDX, r);
        `CHK(r, 32'h0000_0000)
        rd(IEN_IDX, r);
        `CHK(r, 32'h0000_0000)
        rd(MS_IDX, r);
        `CHK(r, exp_ms(46801, 1'b0))
        rd(HR_IDX, r);
        `CHK(r, exp_hr(46801, 1'b0, 1'b0))
        wr(16'h56C1, 32'h0000_FFFF);
        rd(16'h56C1, r);
        `CHK(r, 32'h0000_0000)
        rd(CTL_IDX, r);
        `CHK(r, 32'h0000_0000)
        $display("reset retention done");
        complete_run();
    end

    // about 42k cycles expected; cut a hang well before the budget
    initial begin
        repeat (80000) @(posedge ref_clk);
        failures++;
        complete_run();
    end

endmodule
